// File: rtl/admc_pkg.sv
// package: register map, field positions and constants for the mode control bank
package admc_pkg;
    // printed offsets are indices (not all multiples of four): byte address = 4 * index
    localparam logic [6:0]  ADMC_IDX_ZERO_MUTE  = 7'h12;
    localparam logic [6:0]  ADMC_IDX_CHAN_DEEMP = 7'h13;
    localparam logic [6:0]  ADMC_IDX_FORMAT     = 7'h14;
    localparam logic [6:0]  ADMC_IDX_RESERVED   = 7'h15;
    localparam logic [6:0]  ADMC_IDX_MODE       = 7'h16;
    localparam logic [6:0]  ADMC_IDX_STATUS     = 7'h17;
    localparam logic [11:0] ADMC_ADDR_ZERO_MUTE  = 12'h048;
    localparam logic [11:0] ADMC_ADDR_CHAN_DEEMP = 12'h04C;
    localparam logic [11:0] ADMC_ADDR_FORMAT     = 12'h050;
    localparam logic [11:0] ADMC_ADDR_RESERVED   = 12'h054;
    localparam logic [11:0] ADMC_ADDR_MODE       = 12'h058;
    localparam logic [11:0] ADMC_ADDR_STATUS     = 12'h05C;
    // control word layout
    localparam int ADMC_WORD_ZERO_BIT = 15;
    localparam int ADMC_IDX_MSB       = 14;
    localparam int ADMC_IDX_LSB       = 8;
    // register 18 fields
    localparam int ADMC_OVERSAMPLE_BIT = 6;
    localparam int ADMC_ZDMUTE_BIT     = 4;
    // register 19 fields
    localparam int ADMC_DEEMP_RATE_LSB = 5;
    localparam int ADMC_DEEMP_EN_BIT   = 4;
    localparam int ADMC_DIS_RIGHT_BIT  = 1;
    localparam int ADMC_DIS_LEFT_BIT   = 0;
    // register 20 fields
    localparam int ADMC_CLKSRC_BIT     = 7;
    localparam int ADMC_ROLLOFF_BIT    = 6;
    localparam int ADMC_FORMAT_LSB     = 0;
    // register 22 fields
    localparam int ADMC_SYSTEM_SOFT_RESET_BIT       = 7;
    localparam int ADMC_BITSTREAM_BIT  = 5;
    localparam int ADMC_BSFILT_LSB     = 3;
    localparam int ADMC_FORM_BIT       = 2;
    localparam int ADMC_ZPOL_BIT       = 1;
    localparam int ADMC_PHASE_BIT      = 0;
    // reset values
    localparam logic [7:0] ADMC_RST_DATA = 8'h00;
    // zero detect length in word clock periods
    localparam int ADMC_ZERO_PERIODS = 1024;
    // oversampling encodings
    typedef enum logic [1:0] {
        ADMC_OSR_32X  = 2'b00,
        ADMC_OSR_64X  = 2'b01,
        ADMC_OSR_128X = 2'b10
    } admc_osr_t;
    typedef enum logic [2:0] {
        ADMC_FMT_RJ24 = 3'b000,
        ADMC_FMT_RJ20 = 3'b001,
        ADMC_FMT_RJ18 = 3'b010,
        ADMC_FMT_RJ16 = 3'b011,
        ADMC_FMT_I2S  = 3'b100,
        ADMC_FMT_LJ24 = 3'b101
    } admc_fmt_t;
endpackage

// File: rtl/admc_zero_if.sv
// interface: zero detector controls and results
`timescale 1ns/100ps
interface admc_zero_if;
    logic enable;
    logic word_tick;
    logic left_zero_sample;
    logic right_zero_sample;
    logic left_zero;
    logic right_zero;
    modport ctrl (output enable, output word_tick, output left_zero_sample, output right_zero_sample,
                  input left_zero, input right_zero);
    modport det  (input enable, input word_tick, input left_zero_sample, input right_zero_sample,
                  output left_zero, output right_zero);
endinterface

// File: rtl/admc_zero_detect.sv
// per-channel zero run detector counted in word clock periods
`timescale 1ns/100ps
module admc_zero_detect #(
    parameter int ZERO_PERIODS = 1024
) (
    // clock and reset
    input  wire logic core_clk,
    input  wire logic reset_n,
    // detector link
    admc_zero_if.det  zif
);
    import admc_pkg::*;
    localparam int CW = $clog2(ZERO_PERIODS + 1);
    localparam logic [CW-1:0] LIMIT = CW'(ZERO_PERIODS);

    logic [CW-1:0] left_count;
    logic [CW-1:0] right_count;

    function automatic logic [CW-1:0] admc_step(input logic [CW-1:0] cnt, input logic zero);
        if (!zero)
            return '0;
        return (cnt == LIMIT) ? cnt : cnt + CW'(1);
    endfunction

    always_ff @(posedge core_clk) begin
        if (!reset_n || !zif.enable) begin
            left_count  <= '0;
            right_count <= '0;
        end else if (zif.word_tick) begin
            left_count  <= admc_step(left_count, zif.left_zero_sample);
            right_count <= admc_step(right_count, zif.right_zero_sample);
        end
    end

    assign zif.left_zero  = (left_count == LIMIT);
    assign zif.right_zero = (right_count == LIMIT);
endmodule

// File: rtl/admc_mode_regs.sv
// mode control register bank on APB with zero flags and output control
//
// Operation
// - zero-detect mute enable, flags unaffected
// - oversample bit doubles modulator rate
// - channel disable holds output at midscale
// - de-emphasis enable, multibit mode only
// - de-emphasis rate field, 11 reserved
// - three-bit serial format field
// - roll-off select, multibit only
// - bitstream clock source pin select
// - register 21 not writable, zero data
// - phase invert both outputs
// - zero flag polarity select
// - separate flags per channel
// - combined flag on right pin only
// - bitstream filter select, 11 reserved
// - mode bit: multibit or bitstream
// - word layout: zero, index, data
// - zero after 1024 periods, multibit only
// - soft reset bit acts like power-on
//
// Design decision made here: register access over APB.
`timescale 1ns/100ps
module admc_mode_regs #(
    parameter int ZERO_PERIODS = admc_pkg::ADMC_ZERO_PERIODS
) (
    // clock and reset
    input  wire logic             core_clk,
    input  wire logic             reset_n,
    // apb slave
    input  wire logic             psel,
    input  wire logic             penable,
    input  wire logic             pwrite,
    input  wire logic [11:0]      paddr,
    input  wire logic [31:0]      pwdata,
    output logic                  pready,
    output logic                  pslverr,
    output logic [31:0]           prdata,
    // audio side inputs
    input  wire logic             word_clock_pin,
    input  wire logic             left_sample_zero,
    input  wire logic             right_sample_zero,
    input  wire logic             sysclk_ge_256fs,
    // output controls
    output logic                  left_output_midscale,
    output logic                  right_output_midscale,
    output logic                  output_phase_invert,
    output admc_pkg::admc_osr_t   modulator_rate,
    output logic                  deemphasis_active,
    output logic [1:0]            deemphasis_rate_select,
    output admc_pkg::admc_fmt_t   audio_format_select,
    output logic                  rolloff_select,
    output logic                  bitstream_clock_source_select,
    output logic [1:0]            bitstream_filter_select,
    output logic                  bitstream_mode_select,
    output logic                  system_reset_pulse,
    // zero flag pins
    output logic                  left_zero_flag_pin,
    output logic                  right_zero_flag_pin
);
    import admc_pkg::*;

    // stored fields
    logic        zero_detect_mute_enable;
    logic        oversample_select;
    logic        left_output_disable;
    logic        right_output_disable;
    logic        deemphasis_enable;
    logic [1:0]  deemph_rate;
    logic [2:0]  format_code;
    logic        rolloff;
    logic        clk_source;
    logic        soft_reset_req;
    logic        bitstream_mode;
    logic [1:0]  bs_filter;
    logic        zero_flag_form_select;
    logic        zero_flag_polarity;
    logic        phase_invert;
    logic        bad_reserved_write;
    logic        word_clock_prev;

    logic        int_rst_n;
    logic        wr_en;
    logic        rd_en;
    logic [6:0]  wr_index;
    logic [7:0]  wr_data;
    logic        word_ok;
    logic        left_zero;
    logic        right_zero;
    logic        both_zero;
    logic        left_flag_raw;
    logic        right_flag_raw;

    admc_zero_if zif ();

    // word address to register index
    function automatic logic [6:0] admc_addr_index(input logic [11:0] addr);
        return addr[8:2];
    endfunction

    // soft reset acts as power-on for the whole bank
    assign int_rst_n = reset_n && !soft_reset_req;

    assign wr_en    = psel && penable && pwrite;
    assign rd_en    = psel && !penable && !pwrite;
    assign wr_index = pwdata[ADMC_IDX_MSB:ADMC_IDX_LSB];
    assign wr_data  = pwdata[7:0];
    // word accepted only with top bit zero and index matching address
    assign word_ok  = !pwdata[ADMC_WORD_ZERO_BIT] && (paddr[1:0] == 2'b00)
                      && (wr_index == admc_addr_index(paddr));

    // no wait states: every access completes at once
    assign pready = 1'b1;

    // refused transfers raise slave error and store nothing, but nonzero register 21 data sets its status flag
    always_comb begin
        pslverr = 1'b0;
        if (psel && penable) begin
            if (paddr[1:0] != 2'b00)
                pslverr = 1'b1;
            else if (pwrite && !word_ok)
                pslverr = 1'b1;
            else if (pwrite && paddr == ADMC_ADDR_RESERVED && wr_data != ADMC_RST_DATA)
                pslverr = 1'b1;
            else if (paddr != ADMC_ADDR_ZERO_MUTE && paddr != ADMC_ADDR_CHAN_DEEMP
                     && paddr != ADMC_ADDR_FORMAT && paddr != ADMC_ADDR_RESERVED
                     && paddr != ADMC_ADDR_MODE && paddr != ADMC_ADDR_STATUS)
                pslverr = 1'b1;
            else if (pwrite && paddr == ADMC_ADDR_STATUS)
                pslverr = 1'b1;
        end
    end

    // register 18
    always_ff @(posedge core_clk) begin
        if (!int_rst_n) begin
            zero_detect_mute_enable <= 1'b0;
            oversample_select       <= 1'b0;
        end else if (wr_en && word_ok && paddr == ADMC_ADDR_ZERO_MUTE) begin
            zero_detect_mute_enable <= wr_data[ADMC_ZDMUTE_BIT];
            oversample_select       <= wr_data[ADMC_OVERSAMPLE_BIT];
        end
    end

    // register 19
    always_ff @(posedge core_clk) begin
        if (!int_rst_n) begin
            left_output_disable  <= 1'b0;
            right_output_disable <= 1'b0;
            deemphasis_enable    <= 1'b0;
            deemph_rate          <= 2'h0;
        end else if (wr_en && word_ok && paddr == ADMC_ADDR_CHAN_DEEMP) begin
            left_output_disable  <= wr_data[ADMC_DIS_LEFT_BIT];
            right_output_disable <= wr_data[ADMC_DIS_RIGHT_BIT];
            deemphasis_enable    <= wr_data[ADMC_DEEMP_EN_BIT];
            deemph_rate          <= wr_data[ADMC_DEEMP_RATE_LSB +: 2];
        end
    end

    // register 20
    always_ff @(posedge core_clk) begin
        if (!int_rst_n) begin
            format_code <= 3'h0;
            rolloff     <= 1'b0;
            clk_source  <= 1'b0;
        end else if (wr_en && word_ok && paddr == ADMC_ADDR_FORMAT) begin
            format_code <= wr_data[ADMC_FORMAT_LSB +: 3];
            rolloff     <= wr_data[ADMC_ROLLOFF_BIT];
            clk_source  <= wr_data[ADMC_CLKSRC_BIT];
        end
    end

    // register 21: nothing stored, nonzero data flagged
    always_ff @(posedge core_clk) begin
        if (!int_rst_n)
            bad_reserved_write <= 1'b0;
        else if (wr_en && word_ok && paddr == ADMC_ADDR_RESERVED && wr_data != ADMC_RST_DATA)
            bad_reserved_write <= 1'b1;
    end

    // register 22; soft reset bit self clears through the reset it causes
    always_ff @(posedge core_clk) begin
        if (!int_rst_n) begin
            soft_reset_req        <= 1'b0;
            bitstream_mode        <= 1'b0;
            bs_filter             <= 2'h0;
            zero_flag_form_select <= 1'b0;
            zero_flag_polarity    <= 1'b0;
            phase_invert          <= 1'b0;
        end else if (wr_en && word_ok && paddr == ADMC_ADDR_MODE) begin
            soft_reset_req        <= wr_data[ADMC_SYSTEM_SOFT_RESET_BIT];
            bitstream_mode        <= wr_data[ADMC_BITSTREAM_BIT];
            bs_filter             <= wr_data[ADMC_BSFILT_LSB +: 2];
            zero_flag_form_select <= wr_data[ADMC_FORM_BIT];
            zero_flag_polarity    <= wr_data[ADMC_ZPOL_BIT];
            phase_invert          <= wr_data[ADMC_PHASE_BIT];
        end
    end

    // read back
    // loaded in setup phase so it stands through the access phase
    always_ff @(posedge core_clk) begin
        if (!int_rst_n) begin
            prdata <= 32'h0000_0000;
        end else if (rd_en) begin
            if (paddr == ADMC_ADDR_ZERO_MUTE)
                prdata <= {17'h0, ADMC_IDX_ZERO_MUTE, 1'b0, oversample_select, 1'b0,
                           zero_detect_mute_enable, 4'h0};
            else if (paddr == ADMC_ADDR_CHAN_DEEMP)
                prdata <= {17'h0, ADMC_IDX_CHAN_DEEMP, 1'b0, deemph_rate, deemphasis_enable, 2'h0,
                           right_output_disable, left_output_disable};
            else if (paddr == ADMC_ADDR_FORMAT)
                prdata <= {17'h0, ADMC_IDX_FORMAT, clk_source, rolloff, 3'h0, format_code};
            else if (paddr == ADMC_ADDR_RESERVED)
                prdata <= {17'h0, ADMC_IDX_RESERVED, 8'h00};
            else if (paddr == ADMC_ADDR_MODE)
                prdata <= {17'h0, ADMC_IDX_MODE, 2'h0, bitstream_mode, bs_filter,
                           zero_flag_form_select, zero_flag_polarity, phase_invert};
            else if (paddr == ADMC_ADDR_STATUS)
                prdata <= {27'h0, bad_reserved_write, both_zero, right_zero, left_zero, bitstream_mode};
            else
                prdata <= 32'h0000_0000;
        end
    end

    // word clock edge gives one tick per sample period
    always_ff @(posedge core_clk) begin
        if (!int_rst_n)
            word_clock_prev <= 1'b0;
        else
            word_clock_prev <= word_clock_pin;
    end

    // detector held clear while bitstream mode is selected
    assign zif.enable            = !bitstream_mode;
    assign zif.word_tick         = word_clock_pin && !word_clock_prev;
    assign zif.left_zero_sample  = left_sample_zero;
    assign zif.right_zero_sample = right_sample_zero;

    admc_zero_detect #(
        .ZERO_PERIODS (ZERO_PERIODS)
    ) u_zero (
        .core_clk (core_clk),
        .reset_n  (int_rst_n),
        .zif      (zif)
    );

    assign left_zero  = zif.left_zero;
    assign right_zero = zif.right_zero;
    assign both_zero  = left_zero && right_zero;

    // flags ignore the mute enable
    assign left_flag_raw  = zero_flag_form_select ? 1'b0 : left_zero;
    assign right_flag_raw = zero_flag_form_select ? both_zero : right_zero;

    // flag pins registered so they never glitch
    always_ff @(posedge core_clk) begin
        if (!int_rst_n) begin
            left_zero_flag_pin  <= 1'b0;
            right_zero_flag_pin <= 1'b0;
        end else begin
            left_zero_flag_pin  <= zero_flag_form_select ? 1'b0 : (left_flag_raw ^ zero_flag_polarity);
            right_zero_flag_pin <= right_flag_raw ^ zero_flag_polarity;
        end
    end

    // output controls
    always_ff @(posedge core_clk) begin
        if (!int_rst_n) begin
            left_output_midscale  <= 1'b0;
            right_output_midscale <= 1'b0;
            deemphasis_active     <= 1'b0;
            modulator_rate        <= ADMC_OSR_64X;
        end else begin
            // zero mute needs both channels zero together
            left_output_midscale  <= left_output_disable
                                     || (zero_detect_mute_enable && both_zero && !bitstream_mode);
            right_output_midscale <= right_output_disable
                                     || (zero_detect_mute_enable && both_zero && !bitstream_mode);
            deemphasis_active     <= deemphasis_enable && !bitstream_mode;
            // rate tracks the clock ratio as well as the select bit
            if (sysclk_ge_256fs)
                modulator_rate <= oversample_select ? ADMC_OSR_128X : ADMC_OSR_64X;
            else
                modulator_rate <= oversample_select ? ADMC_OSR_64X : ADMC_OSR_32X;
        end
    end

    // roll-off, clock source and filter outputs driven to zero in the other mode; register reads return the stored values
    assign output_phase_invert           = phase_invert;
    assign deemphasis_rate_select        = deemph_rate;
    assign audio_format_select           = admc_fmt_t'(format_code);
    assign rolloff_select                = rolloff && !bitstream_mode;
    assign bitstream_clock_source_select = clk_source && bitstream_mode;
    assign bitstream_filter_select       = bitstream_mode ? bs_filter : 2'h0;
    assign bitstream_mode_select         = bitstream_mode;
    assign system_reset_pulse            = soft_reset_req;
endmodule

// File: verif/admc_mode_regs_chk.sv
// checker: concurrent properties on the mode control bank ports
`timescale 1ns/100ps
module admc_mode_regs_chk (
    // clock and reset
    input wire logic                core_clk,
    input wire logic                reset_n,
    // apb
    input wire logic                psel,
    input wire logic                penable,
    input wire logic                pwrite,
    input wire logic [11:0]         paddr,
    input wire logic [31:0]         pwdata,
    input wire logic                pslverr,
    // controls
    input wire logic                sysclk_ge_256fs,
    input wire admc_pkg::admc_osr_t modulator_rate,
    input wire logic                deemphasis_active,
    input wire logic                rolloff_select,
    input wire logic                bitstream_clock_source_select,
    input wire logic [1:0]          bitstream_filter_select,
    input wire logic                bitstream_mode_select,
    input wire logic                output_phase_invert,
    input wire logic                system_reset_pulse
);
    import admc_pkg::*;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);
    sequence system_soft_reset_write;
        psel && penable && pwrite && paddr == ADMC_ADDR_MODE && pwdata[15:7] == {1'b0, ADMC_IDX_MODE, 1'b1};
    endsequence
    sequence fields_cleared;
        !bitstream_mode_select && !output_phase_invert && !rolloff_select;
    endsequence
    chk_system_soft_reset_pulse_once: assert property (system_soft_reset_write |=> system_reset_pulse ##1 !system_reset_pulse)
        else $error("soft reset pulse wrong");
    chk_system_soft_reset_fields_clear: assert property (system_reset_pulse |-> ##[0:2] fields_cleared)
        else $error("fields not cleared by soft reset");
    chk_rate_fast_clock: assert property (
        sysclk_ge_256fs && $past(sysclk_ge_256fs) |-> modulator_rate != ADMC_OSR_32X)
        else $error("rate too low for fast clock");
    chk_rate_slow_clock: assert property (
        !sysclk_ge_256fs && !$past(sysclk_ge_256fs) |-> modulator_rate != ADMC_OSR_128X)
        else $error("rate too high for slow clock");
    chk_filter_gate_mb: assert property (
        !bitstream_mode_select && !$past(bitstream_mode_select) |-> bitstream_filter_select == 2'h0)
        else $error("bitstream filter active in multibit");
    chk_clksrc_gate_mb: assert property (
        !bitstream_mode_select && !$past(bitstream_mode_select) |-> !bitstream_clock_source_select)
        else $error("clock source active in multibit");
    chk_multibit_gate_bs: assert property (
        bitstream_mode_select && $past(bitstream_mode_select) |-> !deemphasis_active && !rolloff_select)
        else $error("multibit field active in bitstream");
    chk_reserved_refused: assert property (
        psel && penable && pwrite && paddr == ADMC_ADDR_RESERVED && pwdata[7:0] != 8'h00 |-> pslverr)
        else $error("reserved write not refused");
    chk_word_zero_bit: assert property (psel && penable && pwrite && pwdata[15] |-> pslverr)
        else $error("word with top bit set accepted");
endmodule
bind admc_mode_regs admc_mode_regs_chk u_chk (.core_clk, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pslverr,
    .sysclk_ge_256fs, .modulator_rate, .deemphasis_active, .rolloff_select, .bitstream_clock_source_select,
    .bitstream_filter_select, .bitstream_mode_select, .output_phase_invert, .system_reset_pulse);

// File: verif/admc_audio_src.sv
// partner: audio source making word clock and per-channel zero levels
`timescale 1ns/100ps
module admc_audio_src #(
    parameter int HALF_PERIOD = 4
) (
    // clock
    input wire logic core_clk,
    // requested zero levels
    input wire logic left_zero_req,
    input wire logic right_zero_req,
    // audio side
    output logic     word_clock_pin,
    output logic     left_sample_zero,
    output logic     right_sample_zero
);
    int cnt = 0;
    initial begin
        word_clock_pin = 1'b0;
        left_sample_zero = 1'b0;
        right_sample_zero = 1'b0;
    end
    always @(posedge core_clk) begin
        cnt <= (cnt == HALF_PERIOD - 1) ? 0 : cnt + 1;
        if (cnt == HALF_PERIOD - 1) begin
            word_clock_pin <= !word_clock_pin;
        end
    end
    // samples change at the falling word clock, away from the counting edge
    always @(posedge core_clk) begin
        if (cnt == HALF_PERIOD - 1 && word_clock_pin) begin
            left_sample_zero <= left_zero_req;
            right_sample_zero <= right_zero_req;
        end
    end
endmodule

// File: verif/audio_dac_mode_control_regs_tb.sv
// testbench: apb access, field decode, zero flags and soft reset
`timescale 1ns/100ps
module audio_dac_mode_control_regs_tb;
    import admc_pkg::*;
    logic        core_clk = 1'b0;
    logic        reset_n = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000;
    logic        sysclk_ge_256fs = 1'b1;
    logic        left_zero_req = 1'b0;
    logic        right_zero_req = 1'b0;
    logic        pready, pslverr, word_clock_pin, left_sample_zero, right_sample_zero, erv;
    logic        left_output_midscale, right_output_midscale, output_phase_invert, deemphasis_active;
    logic        rolloff_select, bitstream_clock_source_select, bitstream_mode_select, system_reset_pulse;
    logic        left_zero_flag_pin, right_zero_flag_pin;
    logic [1:0]  deemphasis_rate_select, bitstream_filter_select;
    logic [31:0] prdata, rdv;
    admc_osr_t   modulator_rate;
    admc_fmt_t   audio_format_select;
    int          num_errors = 0;
    int          comparisons = 0;
    logic [5:0]  zt [5] = '{6'h22, 6'h25, 6'h39, 6'h28, 6'h3C};
    always #2.5 core_clk = ~core_clk;
    admc_mode_regs #(.ZERO_PERIODS(4)) dut (.core_clk, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
        .pslverr, .prdata, .word_clock_pin, .left_sample_zero, .right_sample_zero, .sysclk_ge_256fs,
        .left_output_midscale, .right_output_midscale, .output_phase_invert, .modulator_rate, .deemphasis_active,
        .deemphasis_rate_select, .audio_format_select, .rolloff_select, .bitstream_clock_source_select,
        .bitstream_filter_select, .bitstream_mode_select, .system_reset_pulse, .left_zero_flag_pin,
        .right_zero_flag_pin);
    admc_audio_src #(.HALF_PERIOD(4)) u_src (.core_clk, .left_zero_req, .right_zero_req, .word_clock_pin,
        .left_sample_zero, .right_sample_zero);
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        @(posedge core_clk);
        while (pready !== 1'b1) begin
            @(posedge core_clk);
        end
        rdv = prdata;
        erv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        repeat (2) @(posedge core_clk);
        #1;
    endtask
    task automatic wr(input logic [6:0] idx, input logic [7:0] d, input logic exp_err);
        xfer(1'b1, {3'h0, idx, 2'h0}, {16'h0000, 1'b0, idx, d});
        check(erv, exp_err, "slave error");
    endtask
    task automatic wait_cycles(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    task summarize;
        $display("comparisons %0d mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    initial begin
        #100000;
        num_errors++;
        $display("wrong value at %0t: watchdog expired", $time);
        summarize();
    end
    initial begin
        repeat (5) @(posedge core_clk);
        reset_n <= 1'b1;
        wait_cycles(2);
        check({bitstream_mode_select, output_phase_invert, rolloff_select, left_output_midscale,
               right_output_midscale, left_zero_flag_pin, right_zero_flag_pin}, 32'h0, "reset fields");
        check(audio_format_select, ADMC_FMT_RJ24, "reset format");
        check(modulator_rate, ADMC_OSR_64X, "reset rate");
        for (int f = 0; f < 6; f++) begin
            wr(ADMC_IDX_FORMAT, {1'b1, f[0], 3'h0, f[2:0]}, 1'b0);
            check(audio_format_select, f, "format");
            check(rolloff_select, f % 2, "rolloff");
            check(bitstream_clock_source_select, 32'h0, "clock source in multibit");
        end
        for (int r = 0; r < 3; r++) begin
            wr(ADMC_IDX_CHAN_DEEMP, {1'b0, r[1:0], 1'b1, 2'h0, r[1:0]}, 1'b0);
            check(deemphasis_active, 32'h1, "deemphasis on");
            check(deemphasis_rate_select, r, "deemphasis rate");
            check({right_output_midscale, left_output_midscale}, r, "channel disable");
        end
        wr(ADMC_IDX_ZERO_MUTE, 8'h40, 1'b0);
        check(modulator_rate, ADMC_OSR_128X, "fast clock high rate");
        @(posedge core_clk);
        sysclk_ge_256fs <= 1'b0;
        wait_cycles(3);
        check(modulator_rate, ADMC_OSR_64X, "slow clock high rate");
        wr(ADMC_IDX_ZERO_MUTE, 8'h00, 1'b0);
        check(modulator_rate, ADMC_OSR_32X, "slow clock base rate");
        @(posedge core_clk);
        sysclk_ge_256fs <= 1'b1;
        wr(ADMC_IDX_FORMAT, 8'hC0, 1'b0);
        left_zero_req <= 1'b1;
        right_zero_req <= 1'b1;
        for (int k = 0; k < 3; k++) begin
            wr(ADMC_IDX_MODE, {2'h0, 1'b1, k[1:0], 3'h1}, 1'b0);
            check(bitstream_filter_select, k, "bitstream filter");
            check({bitstream_mode_select, bitstream_clock_source_select, output_phase_invert}, 32'h7, "bs");
            check({deemphasis_active, rolloff_select}, 32'h0, "multibit fields in bs");
        end
        wait_cycles(80);
        check({left_zero_flag_pin, right_zero_flag_pin}, 32'h0, "flags in bitstream");
        wr(ADMC_IDX_CHAN_DEEMP, 8'h00, 1'b0);
        for (int i = 0; i < 5; i++) begin
            left_zero_req <= zt[i][5];
            right_zero_req <= zt[i][4];
            wr(ADMC_IDX_MODE, {5'h00, zt[i][3:2], 1'b0}, 1'b0);
            wait_cycles(80);
            check({left_zero_flag_pin, right_zero_flag_pin}, zt[i][1:0], "zero flags");
        end
        wr(ADMC_IDX_MODE, 8'h00, 1'b0);
        wr(ADMC_IDX_ZERO_MUTE, 8'h10, 1'b0);
        check({left_output_midscale, right_output_midscale}, 32'h3, "zero mute");
        check({left_zero_flag_pin, right_zero_flag_pin}, 32'h3, "flags with mute");
        wr(ADMC_IDX_ZERO_MUTE, 8'h00, 1'b0);
        check({left_output_midscale, right_output_midscale}, 32'h0, "mute off");
        check({left_zero_flag_pin, right_zero_flag_pin}, 32'h3, "flags without mute");
        wr(ADMC_IDX_RESERVED, 8'h01, 1'b1);
        wr(ADMC_IDX_RESERVED, 8'h00, 1'b0);
        xfer(1'b0, ADMC_ADDR_STATUS, 32'h0);
        check(rdv, 32'h0000_001E, "status");
        xfer(1'b1, ADMC_ADDR_MODE, 32'h00009621);
        check({erv, bitstream_mode_select, output_phase_invert}, 32'h4, "top bit set");
        xfer(1'b1, ADMC_ADDR_MODE, {16'h0000, 1'b0, ADMC_IDX_FORMAT, 8'h21});
        check({erv, bitstream_mode_select}, 32'h2, "index mismatch");
        xfer(1'b0, ADMC_ADDR_MODE, 32'h0);
        check(rdv[14:8], ADMC_IDX_MODE, "read index");
        xfer(1'b0, 12'h100, 32'h0);
        check(erv, 1'b1, "unmapped read error");
        check(rdv, 32'h0, "unmapped read data");
        wr(ADMC_IDX_FORMAT, 8'h45, 1'b0);
        wr(ADMC_IDX_MODE, 8'h81, 1'b0);
        check({output_phase_invert, rolloff_select}, 32'h0, "soft reset fields");
        check(audio_format_select, ADMC_FMT_RJ24, "soft reset format");
        summarize();
    end
endmodule
